// *** shared/uvr_pkg.sv ***
/*
  Shared constants of the transceiver vendor register bank: register
  addresses, field positions, reset values, the audio key and the timing
  of the identification resistance measurement.
  Assumes the register bank runs on the 125 MHz ULPI-side clock.
*/
package uvr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  // measurement length as a time, and its cycle count derived from it
  localparam int unsigned MEASURE_TIME_NS = 282000;
  localparam int unsigned MEASURE_CYCLES = MEASURE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned MEASURE_CNT_W = 16;

  // highest address reachable as an immediate register
  localparam logic [7:0] IMMEDIATE_TOP = 8'h3F;
  localparam logic [7:0] IMMEDIATE_MASK = 8'h3F;

  localparam logic [7:0] ADDR_HS_DRIVE_AMPLITUDE = 8'h31;
  localparam logic [7:0] ADDR_HEADSET_SOUND_MODE = 8'h33;
  localparam logic [7:0] ADDR_ID_MEASURE_CONTROL = 8'h36;
  localparam logic [7:0] ADDR_ID_MEASURE_CONTROL_SET = 8'h37;
  localparam logic [7:0] ADDR_ID_MEASURE_CONTROL_CLEAR = 8'h38;
  localparam logic [7:0] ADDR_PIN_SUPPLY_CONTROL = 8'h39;
  localparam logic [7:0] ADDR_PIN_SUPPLY_CONTROL_SET = 8'h3A;
  localparam logic [7:0] ADDR_PIN_SUPPLY_CONTROL_CLEAR = 8'h3B;

  // drive amplitude field
  localparam int unsigned BOOST_LSB = 5;
  localparam int unsigned BOOST_MSB = 6;
  localparam logic [1:0] BOOST_NOMINAL = 2'h0;
  localparam logic [1:0] BOOST_RESERVED = 2'h1;
  localparam logic [1:0] BOOST_PLUS_7P4 = 2'h2;
  localparam logic [1:0] BOOST_PLUS_3P7 = 2'h3;

  // headset audio key
  localparam int unsigned KEY_MSB = 3;
  localparam logic [3:0] SOUND_KEY = 4'hA;
  localparam logic [3:0] KEY_RESET = 4'h0;

  // id measurement control fields
  localparam int unsigned CODE_MSB = 2;
  localparam int unsigned DONE_BIT = 3;
  localparam int unsigned GO_BIT = 4;
  localparam int unsigned SPARE_BIT = 5;
  localparam int unsigned IRQ_EN_BIT = 6;
  localparam logic [2:0] CODE_RESET = 3'h0;
  localparam logic [2:0] CODE_ZERO_OHM = 3'h0;
  localparam logic [2:0] CODE_75_OHM = 3'h1;
  localparam logic [2:0] CODE_100K = 3'h2;
  localparam logic [2:0] CODE_200K = 3'h3;
  localparam logic [2:0] CODE_440K = 3'h4;
  localparam logic [2:0] CODE_FLOATING = 3'h5;
  localparam logic [2:0] CODE_ERROR = 3'h7;

  // pin and supply control fields
  localparam int unsigned EXCHANGE_BIT = 1;
  localparam int unsigned SERIAL_LDO_LSB = 2;
  localparam int unsigned SERIAL_LDO_MSB = 3;
  localparam int unsigned PLUS_PULLUP_BIT = 4;
  localparam int unsigned MINUS_PULLUP_BIT = 5;
  localparam int unsigned BUS_LDO_LSB = 6;
  localparam int unsigned BUS_LDO_MSB = 7;
  // bit 0 is reserved and always reads zero
  localparam logic [7:0] PIN_SUPPLY_MASK = 8'hFE;
  localparam logic [7:0] PIN_SUPPLY_RESET = 8'h04;

  // regulator levels: 3.3 V, 3.0 V, 2.75 V, 2.5 V
  localparam logic [1:0] LDO_3V3 = 2'h0;
  localparam logic [1:0] LDO_3V0 = 2'h1;
  localparam logic [1:0] LDO_2V75 = 2'h2;
  localparam logic [1:0] LDO_2V5 = 2'h3;

  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage : uvr_pkg

// *** src/uvr_id_meter.sv ***
/*
  Identification resistance converter timing: a start pulse opens a fixed
  measurement window, at its end the sensed code is captured and a one
  cycle finish pulse is given.
  Assumes the sensed code from the analog front end is stable and
  synchronous to ref_clk at the end of the window.
*/
`timescale 1ns/1ps
module uvr_id_meter #(
  parameter int unsigned MEASURE_CYCLES = uvr_pkg::MEASURE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic measure_start,
  input wire logic [2:0] sense_code,
  output logic measure_finish,
  output logic [2:0] result_code
);

  typedef enum logic [1:0] {
    UVR_MEAS_IDLE = 2'b01,
    UVR_MEAS_BUSY = 2'b10
  } uvr_meas_state_t;

  typedef struct packed {
    uvr_meas_state_t state;
    logic [uvr_pkg::MEASURE_CNT_W-1:0] count;
    logic finish;
    logic [2:0] code;
  } uvr_meter_t;

  localparam logic [uvr_pkg::MEASURE_CNT_W-1:0] LAST_COUNT =
    uvr_pkg::MEASURE_CNT_W'(MEASURE_CYCLES - 1);

  uvr_meter_t meter_reg;
  uvr_meter_t meter_next;

  always_comb begin
    meter_next = meter_reg;
    meter_next.finish = 1'b0;
    case (meter_reg.state)
      UVR_MEAS_IDLE: begin
        if (measure_start) begin
          meter_next.state = UVR_MEAS_BUSY;
          meter_next.count = '0;
        end
      end
      UVR_MEAS_BUSY: begin
        // a new start during a measurement is ignored
        if (meter_reg.count == LAST_COUNT) begin
          meter_next.state = UVR_MEAS_IDLE;
          meter_next.finish = 1'b1;
          meter_next.code = sense_code;
        end else begin
          meter_next.count = meter_reg.count + 1'b1;
        end
      end
      default: begin
        meter_next.state = UVR_MEAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meter_reg.state <= UVR_MEAS_IDLE;
      meter_reg.count <= '0;
      meter_reg.finish <= 1'b0;
      meter_reg.code <= uvr_pkg::CODE_RESET;
    end else begin
      meter_reg <= meter_next;
    end
  end

  assign measure_finish = meter_reg.finish;
  assign result_code = meter_reg.code;

endmodule : uvr_id_meter

// *** src/uvr_vendor_regs.sv ***
/*
  Vendor register bank of the transceiver, reached by decoded ULPI
  register read and write commands, immediate or extended. Holds the
  drive amplitude, headset key, id measurement control and the pin and
  supply control, and drives the matching controls of the analog side.
  Assumes the ULPI command decoder delivers one-cycle read and write
  strobes synchronous to ref_clk, and that mode inputs are synchronous.
*/
`timescale 1ns/1ps
module uvr_vendor_regs #(
  parameter int unsigned MEASURE_CYCLES = uvr_pkg::MEASURE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_extended,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic carkit_irq_enable,
  input wire logic [2:0] id_sense_code,
  input wire logic uart_mode,
  input wire logic serial_transmit_enable,
  output logic [1:0] hs_drive_boost,
  output logic earpiece_sound_enable,
  output logic data_pin_exchange,
  output logic plus_line_detect_pullup,
  output logic minus_line_detect_pullup,
  output logic [1:0] ldo_level,
  output logic [2:0] id_resistance_code,
  output logic id_measure_done,
  output logic alt_int
);

  typedef struct packed {
    logic [1:0] boost;
    logic [3:0] earpiece_sound_key;
    logic [2:0] id_resistance_code;
    logic id_measure_done;
    logic id_measure_go;
    logic spare;
    logic id_measure_irq_enable;
    logic [7:0] pin_supply;
    logic [7:0] rdata;
    logic rvalid;
    logic alt_int;
    logic sound_on;
    logic exchange;
    logic plus_pullup;
    logic minus_pullup;
    logic [1:0] ldo;
  } uvr_regs_t;

  uvr_regs_t regs_reg;
  uvr_regs_t regs_next;

  logic [7:0] eff_addr;
  logic addr_valid;
  logic [7:0] id_ctrl_view;
  logic [7:0] read_value;
  logic meas_start;
  logic meas_finish;
  logic [2:0] meas_code;
  logic go_written;
  logic id_write;
  logic id_set;
  logic id_clear;
  logic io_write;
  logic io_set;
  logic io_clear;
  logic id_read;
  logic [1:0] serial_level;
  logic [1:0] bus_level;

  // immediate commands carry six address bits, extended ones eight; an
  // extended address at or below the immediate top hits the same register
  always_comb begin
    if (reg_extended) begin
      eff_addr = reg_addr;
    end else begin
      eff_addr = reg_addr & uvr_pkg::IMMEDIATE_MASK;
    end
    addr_valid = (eff_addr <= uvr_pkg::IMMEDIATE_TOP);
  end

  // the conversion register image, identical at all three addresses
  always_comb begin
    id_ctrl_view = uvr_pkg::READ_ZERO;
    id_ctrl_view[uvr_pkg::CODE_MSB:0] = regs_reg.id_resistance_code;
    id_ctrl_view[uvr_pkg::DONE_BIT] = regs_reg.id_measure_done;
    id_ctrl_view[uvr_pkg::GO_BIT] = regs_reg.id_measure_go;
    id_ctrl_view[uvr_pkg::SPARE_BIT] = regs_reg.spare;
    id_ctrl_view[uvr_pkg::IRQ_EN_BIT] = regs_reg.id_measure_irq_enable;
  end

  // read multiplexer; unmapped addresses read as zero
  always_comb begin
    read_value = uvr_pkg::READ_ZERO;
    if (addr_valid) begin
      case (eff_addr)
        uvr_pkg::ADDR_HS_DRIVE_AMPLITUDE: begin
          read_value[uvr_pkg::BOOST_MSB:uvr_pkg::BOOST_LSB] =
            regs_reg.boost;
        end
        uvr_pkg::ADDR_HEADSET_SOUND_MODE: begin
          read_value[uvr_pkg::KEY_MSB:0] =
            regs_reg.earpiece_sound_key;
        end
        uvr_pkg::ADDR_ID_MEASURE_CONTROL,
        uvr_pkg::ADDR_ID_MEASURE_CONTROL_SET,
        uvr_pkg::ADDR_ID_MEASURE_CONTROL_CLEAR: begin
          read_value = id_ctrl_view;
        end
        uvr_pkg::ADDR_PIN_SUPPLY_CONTROL,
        uvr_pkg::ADDR_PIN_SUPPLY_CONTROL_SET,
        uvr_pkg::ADDR_PIN_SUPPLY_CONTROL_CLEAR: begin
          read_value = regs_reg.pin_supply;
        end
        default: begin
          read_value = uvr_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // write address decode for the triple-addressed registers
  always_comb begin
    id_write = reg_write && addr_valid &&
      (eff_addr == uvr_pkg::ADDR_ID_MEASURE_CONTROL);
    id_set = reg_write && addr_valid &&
      (eff_addr == uvr_pkg::ADDR_ID_MEASURE_CONTROL_SET);
    id_clear = reg_write && addr_valid &&
      (eff_addr == uvr_pkg::ADDR_ID_MEASURE_CONTROL_CLEAR);
    io_write = reg_write && addr_valid &&
      (eff_addr == uvr_pkg::ADDR_PIN_SUPPLY_CONTROL);
    io_set = reg_write && addr_valid &&
      (eff_addr == uvr_pkg::ADDR_PIN_SUPPLY_CONTROL_SET);
    io_clear = reg_write && addr_valid &&
      (eff_addr == uvr_pkg::ADDR_PIN_SUPPLY_CONTROL_CLEAR);
    id_read = reg_read && addr_valid &&
      ((eff_addr == uvr_pkg::ADDR_ID_MEASURE_CONTROL) ||
       (eff_addr == uvr_pkg::ADDR_ID_MEASURE_CONTROL_SET) ||
       (eff_addr == uvr_pkg::ADDR_ID_MEASURE_CONTROL_CLEAR));
    go_written = (id_write || id_set) &&
      reg_wdata[uvr_pkg::GO_BIT];
  end

  always_comb begin
    regs_next = regs_reg;
    regs_next.rvalid = reg_read;
    regs_next.rdata = regs_reg.rdata;
    regs_next.alt_int = 1'b0;
    if (reg_read) begin
      regs_next.rdata = read_value;
    end

    // single-address registers
    if (reg_write && addr_valid &&
        (eff_addr == uvr_pkg::ADDR_HS_DRIVE_AMPLITUDE)) begin
      regs_next.boost =
        reg_wdata[uvr_pkg::BOOST_MSB:uvr_pkg::BOOST_LSB];
    end
    if (reg_write && addr_valid &&
        (eff_addr == uvr_pkg::ADDR_HEADSET_SOUND_MODE)) begin
      regs_next.earpiece_sound_key = reg_wdata[uvr_pkg::KEY_MSB:0];
    end

    // conversion register: write replaces, set ors, clear masks out;
    // the done flag is status only and never written
    if (id_write) begin
      regs_next.id_resistance_code = reg_wdata[uvr_pkg::CODE_MSB:0];
      regs_next.id_measure_go = reg_wdata[uvr_pkg::GO_BIT];
      regs_next.spare = reg_wdata[uvr_pkg::SPARE_BIT];
      regs_next.id_measure_irq_enable = reg_wdata[uvr_pkg::IRQ_EN_BIT];
    end else if (id_set) begin
      regs_next.id_resistance_code = regs_reg.id_resistance_code |
        reg_wdata[uvr_pkg::CODE_MSB:0];
      regs_next.id_measure_go = regs_reg.id_measure_go |
        reg_wdata[uvr_pkg::GO_BIT];
      regs_next.spare = regs_reg.spare | reg_wdata[uvr_pkg::SPARE_BIT];
      regs_next.id_measure_irq_enable = regs_reg.id_measure_irq_enable |
        reg_wdata[uvr_pkg::IRQ_EN_BIT];
    end else if (id_clear) begin
      regs_next.id_resistance_code = regs_reg.id_resistance_code &
        ~reg_wdata[uvr_pkg::CODE_MSB:0];
      regs_next.id_measure_go = regs_reg.id_measure_go &
        ~reg_wdata[uvr_pkg::GO_BIT];
      regs_next.spare = regs_reg.spare & ~reg_wdata[uvr_pkg::SPARE_BIT];
      regs_next.id_measure_irq_enable = regs_reg.id_measure_irq_enable &
        ~reg_wdata[uvr_pkg::IRQ_EN_BIT];
    end

    // reading the conversion register consumes the done flag
    if (id_read) begin
      regs_next.id_measure_done = 1'b0;
    end

    // completion beats a same-cycle read or software write, so no result
    // is lost; it loads the code, sets done and drops the start bit
    if (meas_finish) begin
      regs_next.id_resistance_code = meas_code;
      regs_next.id_measure_done = 1'b1;
      regs_next.id_measure_go = 1'b0;
      if (!regs_reg.id_measure_done &&
          (regs_reg.id_measure_irq_enable || carkit_irq_enable)) begin
        regs_next.alt_int = 1'b1;
      end
    end

    // pin and supply register
    if (io_write) begin
      regs_next.pin_supply = reg_wdata & uvr_pkg::PIN_SUPPLY_MASK;
    end else if (io_set) begin
      regs_next.pin_supply = regs_reg.pin_supply |
        (reg_wdata & uvr_pkg::PIN_SUPPLY_MASK);
    end else if (io_clear) begin
      regs_next.pin_supply = regs_reg.pin_supply &
        ~(reg_wdata & uvr_pkg::PIN_SUPPLY_MASK);
    end

    // registered analog controls, taken from the stored fields
    regs_next.sound_on =
      (regs_reg.earpiece_sound_key == uvr_pkg::SOUND_KEY);
    regs_next.exchange = regs_reg.pin_supply[uvr_pkg::EXCHANGE_BIT];
    regs_next.plus_pullup = uart_mode ||
      regs_reg.pin_supply[uvr_pkg::PLUS_PULLUP_BIT];
    regs_next.minus_pullup = uart_mode ||
      regs_reg.pin_supply[uvr_pkg::MINUS_PULLUP_BIT];
    // the serial level only takes over once the transmitter is enabled,
    // so the supply does not drop before the serial link is live
    if (uart_mode && serial_transmit_enable) begin
      regs_next.ldo = serial_level;
    end else begin
      regs_next.ldo = bus_level;
    end
  end

  assign serial_level =
    regs_reg.pin_supply[uvr_pkg::SERIAL_LDO_MSB:uvr_pkg::SERIAL_LDO_LSB];
  assign bus_level =
    regs_reg.pin_supply[uvr_pkg::BUS_LDO_MSB:uvr_pkg::BUS_LDO_LSB];

  // a measurement starts on the cycle the start bit is written as one
  assign meas_start = go_written;

  uvr_id_meter #(
    .MEASURE_CYCLES(MEASURE_CYCLES)
  ) u_id_meter (
    .ref_clk(ref_clk),
    .rst(rst),
    .measure_start(meas_start),
    .sense_code(id_sense_code),
    .measure_finish(meas_finish),
    .result_code(meas_code)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regs_reg.boost <= uvr_pkg::BOOST_NOMINAL;
      regs_reg.earpiece_sound_key <= uvr_pkg::KEY_RESET;
      regs_reg.id_resistance_code <= uvr_pkg::CODE_RESET;
      regs_reg.id_measure_done <= 1'b0;
      regs_reg.id_measure_go <= 1'b0;
      regs_reg.spare <= 1'b0;
      regs_reg.id_measure_irq_enable <= 1'b0;
      regs_reg.pin_supply <= uvr_pkg::PIN_SUPPLY_RESET;
      regs_reg.rdata <= uvr_pkg::READ_ZERO;
      regs_reg.rvalid <= 1'b0;
      regs_reg.alt_int <= 1'b0;
      regs_reg.sound_on <= 1'b0;
      regs_reg.exchange <= 1'b0;
      regs_reg.plus_pullup <= 1'b0;
      regs_reg.minus_pullup <= 1'b0;
      regs_reg.ldo <= uvr_pkg::LDO_3V3;
    end else begin
      regs_reg <= regs_next;
    end
  end

  assign reg_rdata = regs_reg.rdata;
  assign reg_rvalid = regs_reg.rvalid;
  assign hs_drive_boost = regs_reg.boost;
  assign earpiece_sound_enable = regs_reg.sound_on;
  assign data_pin_exchange = regs_reg.exchange;
  assign plus_line_detect_pullup = regs_reg.plus_pullup;
  assign minus_line_detect_pullup = regs_reg.minus_pullup;
  assign ldo_level = regs_reg.ldo;
  assign id_resistance_code = regs_reg.id_resistance_code;
  assign id_measure_done = regs_reg.id_measure_done;
  assign alt_int = regs_reg.alt_int;

endmodule : uvr_vendor_regs

// *** bench/uvr_vendor_regs_assertions.sv ***
/* Port assertions for the vendor register bank.
   Assumes it is bound into uvr_vendor_regs with the same MEASURE_CYCLES. */
`timescale 1ns/1ps
module uvr_vendor_regs_checker #(
  parameter int unsigned MEASURE_CYCLES = 10
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_extended,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic carkit_irq_enable,
  input wire logic [2:0] id_sense_code,
  input wire logic uart_mode,
  input wire logic serial_transmit_enable,
  input wire logic [1:0] hs_drive_boost,
  input wire logic earpiece_sound_enable,
  input wire logic data_pin_exchange,
  input wire logic plus_line_detect_pullup,
  input wire logic minus_line_detect_pullup,
  input wire logic [1:0] ldo_level,
  input wire logic [2:0] id_resistance_code,
  input wire logic id_measure_done,
  input wire logic alt_int
);
  localparam int unsigned MC = MEASURE_CYCLES;
  logic [7:0] ea;
  logic ps_wr;
  logic go_wr;
  logic rd_conv;
  // shadow of the meter window, so the finish edge is pinned exactly
  logic [15:0] left_reg;

  assign ea = reg_extended ? reg_addr : (reg_addr & 8'h3F);
  assign ps_wr = reg_write && ea >= 8'h39 && ea <= 8'h3B;
  assign go_wr = reg_write && reg_wdata[4] && (ea == 8'h36 || ea == 8'h37);
  assign rd_conv = reg_read && ea >= 8'h36 && ea <= 8'h38;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      left_reg <= 16'h0000;
    end else if (left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
    end else if (go_wr) begin
      left_reg <= 16'(MC + 1);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  rvalid_echo_a: assert property (
    1'b1 |=> reg_rvalid == $past(reg_read))
    else $error("read answer out of step");
  unmapped_zero_a: assert property (
    reg_read && ea > 8'h3F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  boost_follow_a: assert property (
    reg_write && ea == 8'h31 |=> hs_drive_boost == $past(reg_wdata[6:5]))
    else $error("drive boost not taken");
  sound_key_a: assert property (
    reg_write && ea == 8'h33 ##1 !(reg_write && ea == 8'h33) |=>
    earpiece_sound_enable == ($past(reg_wdata[3:0], 2) == 4'hA))
    else $error("audio enable wrong for key");
  ldo_choice_a: assert property (
    reg_write && ea == 8'h39 ##1 !ps_wr |=> ldo_level ==
    (($past(uart_mode) && $past(serial_transmit_enable)) ?
    $past(reg_wdata[3:2], 2) : $past(reg_wdata[7:6], 2)))
    else $error("regulator level wrong");
  pullup_forced_a: assert property (
    uart_mode |=> plus_line_detect_pullup && minus_line_detect_pullup)
    else $error("serial mode pull-ups off");
  alt_edge_a: assert property (
    alt_int |-> id_measure_done && !$past(id_measure_done))
    else $error("alt interrupt without done edge");
  alt_cause_a: assert property (
    $rose(id_measure_done) && $past(carkit_irq_enable) |-> alt_int)
    else $error("alt interrupt missing");
  done_arrive_a: assert property (left_reg == 16'h0001 |=>
    id_measure_done && id_resistance_code == $past(id_sense_code))
    else $error("measurement result missing");
  done_timing_a: assert property (
    $rose(id_measure_done) |-> $past(left_reg) == 16'h0001)
    else $error("done at wrong time");
  done_clear_a: assert property (
    rd_conv && left_reg != 16'h0001 |=> !id_measure_done)
    else $error("done not cleared by read");
endmodule : uvr_vendor_regs_checker

bind uvr_vendor_regs uvr_vendor_regs_checker #(
  .MEASURE_CYCLES(MEASURE_CYCLES)
) chk (
  .ref_clk(ref_clk), .rst(rst), .reg_write(reg_write),
  .reg_read(reg_read), .reg_extended(reg_extended), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .carkit_irq_enable(carkit_irq_enable), .id_sense_code(id_sense_code),
  .uart_mode(uart_mode), .serial_transmit_enable(serial_transmit_enable),
  .hs_drive_boost(hs_drive_boost),
  .earpiece_sound_enable(earpiece_sound_enable),
  .data_pin_exchange(data_pin_exchange),
  .plus_line_detect_pullup(plus_line_detect_pullup),
  .minus_line_detect_pullup(minus_line_detect_pullup),
  .ldo_level(ldo_level), .id_resistance_code(id_resistance_code),
  .id_measure_done(id_measure_done), .alt_int(alt_int)
);

// *** bench/uvr_link_model.sv ***
/* Link-side model of the register port: one read or write at a time.
   Assumes strobes are taken at the rising edge of ref_clk. */
`timescale 1ns/1ps
module uvr_link_model (
  input wire logic ref_clk,
  output logic reg_write,
  output logic reg_read,
  output logic reg_extended,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    {reg_write, reg_read, reg_extended, reg_addr, reg_wdata} = '0;
  end

  task automatic xfer(input logic wr, input logic ext,
    input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic ok);
    @(posedge ref_clk);
    #1;
    reg_extended = ext;
    reg_addr = a;
    reg_wdata = d;
    if (wr && (ext ? a : a & 8'h3F) inside {[8'h36:8'h38]}) begin
      reg_wdata[5] = 1'b0;
    end
    reg_write = wr;
    reg_read = !wr;
    @(posedge ref_clk);
    #1;
    // an idle bus shows inverted values, so stale ones are never trusted
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_extended = ~reg_extended;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    ok = wr;
    q = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        q = reg_rdata;
      end else begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask : xfer
endmodule : uvr_link_model

// *** bench/tb.sv ***
/* Self-checking bench of the vendor register bank: register traffic
   through the link model and converter runs over result codes 0 to 5 and 7.
   Assumes ref_clk at 125 MHz and a shortened measurement window. */
`timescale 1ns/1ps
module tb;
  localparam int unsigned MC = 10;
  logic ref_clk, rst, reg_write, reg_read, reg_extended, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, pulls;
  logic carkit_irq_enable, uart_mode, serial_transmit_enable, ok, seen;
  logic [2:0] id_sense_code, id_resistance_code;
  logic [1:0] hs_drive_boost, ldo_level;
  logic earpiece_sound_enable, data_pin_exchange, id_measure_done, alt_int;
  logic plus_line_detect_pullup, minus_line_detect_pullup;
  int n_errors, checks, k;

  assign pulls = {6'h00, plus_line_detect_pullup, minus_line_detect_pullup};

  uvr_vendor_regs #(.MEASURE_CYCLES(MC)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_write(reg_write),
    .reg_read(reg_read), .reg_extended(reg_extended), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .carkit_irq_enable(carkit_irq_enable), .id_sense_code(id_sense_code),
    .uart_mode(uart_mode), .serial_transmit_enable(serial_transmit_enable),
    .hs_drive_boost(hs_drive_boost),
    .earpiece_sound_enable(earpiece_sound_enable),
    .data_pin_exchange(data_pin_exchange),
    .plus_line_detect_pullup(plus_line_detect_pullup),
    .minus_line_detect_pullup(minus_line_detect_pullup),
    .ldo_level(ldo_level), .id_resistance_code(id_resistance_code),
    .id_measure_done(id_measure_done), .alt_int(alt_int)
  );
  uvr_link_model link (
    .ref_clk(ref_clk), .reg_write(reg_write), .reg_read(reg_read),
    .reg_extended(reg_extended), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  task automatic check(input string what, input logic [7:0] seen_v,
    input logic [7:0] exp);
    checks++;
    if (seen_v !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen_v);
    end
  endtask : check

  task automatic wr(input logic ext, input logic [7:0] a,
    input logic [7:0] d);
    link.xfer(1'b1, ext, a, d, rv, ok);
  endtask : wr

  task automatic rdc(input logic ext, input logic [7:0] a,
    input logic [7:0] exp);
    link.xfer(1'b0, ext, a, 8'h00, rv, ok);
    check("answer", 8'(ok), 8'h01);
    check("rdata", rv, exp);
  endtask : rdc

  task automatic idle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    carkit_irq_enable = 1'b0;
    uart_mode = 1'b0;
    serial_transmit_enable = 1'b0;
    id_sense_code = 3'h0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check("done", 8'(id_measure_done), 8'h00);
    rdc(1'b0, 8'h39, 8'h04);
    check("ldo", 8'(ldo_level), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(i[0], 8'h31, {1'b1, i[1:0], 5'h1F});
      check("boost", 8'(hs_drive_boost), 8'(i));
      rdc(i[0], i[0] ? 8'h31 : 8'hF1, {1'b0, i[1:0], 5'h00});
    end
    wr(1'b1, 8'h71, 8'hFF);
    rdc(1'b1, 8'h80, 8'h00);
    rdc(1'b0, 8'h31, 8'h60);
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, 8'h33, i ? 8'h0B : 8'hFA);
      rdc(1'b1, 8'h33, i ? 8'h0B : 8'h0A);
      check("sound", 8'(earpiece_sound_enable), 8'(i == 0));
    end
    wr(1'b0, 8'h39, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      rdc(1'b0, 8'h39 + 8'(i), 8'hFE);
    end
    check("swap", 8'(data_pin_exchange), 8'h01);
    check("pull", pulls, 8'h03);
    check("ldo", 8'(ldo_level), 8'h03);
    wr(1'b0, 8'h3B, 8'h82);
    rdc(1'b0, 8'h3A, 8'h7C);
    check("swap", 8'(data_pin_exchange), 8'h00);
    wr(1'b0, 8'h3A, 8'h02);
    wr(1'b0, 8'h3B, 8'h30);
    rdc(1'b0, 8'h39, 8'h4E);
    check("pull", pulls, 8'h00);
    uart_mode = 1'b1;
    idle();
    check("pull", pulls, 8'h03);
    check("ldo", 8'(ldo_level), 8'h01);
    serial_transmit_enable = 1'b1;
    idle();
    check("ldo", 8'(ldo_level), 8'h03);
    uart_mode = 1'b0;
    serial_transmit_enable = 1'b0;
    // set address with bit five written: the link model keeps it clear
    for (int i = 0; i < 7; i++) begin
      id_sense_code = (i == 6) ? 3'h7 : 3'(i);
      carkit_irq_enable = (i % 3 == 2);
      wr(1'b0, (i % 3 == 1) ? 8'h37 : 8'h36,
        (i % 3 == 1) ? 8'h70 : 8'h10);
      seen = 1'b0;
      for (k = 0; k < 40 && id_measure_done !== 1'b1; k++) begin
        @(posedge ref_clk);
        #1;
        seen = seen | (alt_int === 1'b1);
      end
      // a missing completion ends the scenarios and goes to the report
      if (k == 40) begin
        n_errors++;
        break;
      end
      check("alt", 8'(seen), 8'(i % 3 != 0));
      check("code", 8'(id_resistance_code), 8'(id_sense_code));
      rdc(1'b0, 8'h36 + 8'(i % 3),
        {1'b0, i % 3 == 1, 2'b00, 1'b1, id_sense_code});
      check("done", 8'(id_measure_done), 8'h00);
      wr(1'b0, 8'h38, 8'h40);
      rdc(1'b0, 8'h37, {5'h00, id_sense_code});
    end
    complete_run();
  end
endmodule : tb
